/* include/rbs_pkg.sv */
/*
  Package for the reset and brown-out sequencer: register offsets, field
  positions, reset values, brown-out modes, timing constants and carriers.
  Assumes a single 100 MHz system clock and a byte-addressed Avalon-MM bus.
*/
package rbs_pkg;

  // ----------------------------------------------------------------------
  // Timing constants.
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000; // System clock rate.
  localparam int POWER_UP_DELAY_TIMER_MS = 64; // Nominal power-up delay in milliseconds.
  // Power-up delay in clock cycles, a plain product; CLK_HZ / 1000 truncates, no rounding up.
  localparam int POWER_UP_DELAY_TIMER_CYC = (POWER_UP_DELAY_TIMER_MS * (CLK_HZ / 1000) + 0);
  localparam int FILTER_NS = 1000; // Brown-out dip filter time in ns.
  localparam int FILTER_CYC = (FILTER_NS + 9) / 10; // Rounded up at 10 ns.
  localparam int EXTERNAL_RESET_PIN_FLT_CYC = 4; // Pin noise filter length in cycles.
  localparam int RST_SYNC_LEN = 2; // Reset release synchroniser depth.

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each).
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFF_BROWNOUT_CONTROL = 4'h0; // Soft enable, ready.
  localparam logic [3:0] OFF_SEQ_STATUS = 4'h4; // Sequencer state view.
  localparam int BIT_SOFT_EN = 7; // Soft enable field position.
  localparam int BIT_READY = 0; // Ready status field position.
  localparam logic BROWNOUT_SOFT_EN_RST = 1'b1; // Soft enable reset value.

  // ----------------------------------------------------------------------
  // Brown-out mode encodings.
  // ----------------------------------------------------------------------
  localparam logic [1:0] BOR_MODE_ON = 2'h3; // Always on.
  localparam logic [1:0] BOR_MODE_NOSLEEP = 2'h2; // Off while sleeping.
  localparam logic [1:0] BOR_MODE_SOFT = 2'h1; // Software controlled.
  localparam logic [1:0] BOR_MODE_OFF = 2'h0; // Always off.

  // Sequencer states.
  typedef enum logic [1:0] {
    RBS_ST_HOLD,
    RBS_ST_POWER_UP_DELAY_TIMER,
    RBS_ST_WAIT,
    RBS_ST_RUN
  } rbs_state_type;

  // Static configuration bits, gathered into one carrier.
  typedef struct packed {
    logic [1:0] brownout_mode_select;
    logic power_up_timer_enable_n;
    logic ext_reset_pin_enable;
    logic low_voltage_program_enable;
    logic osc_start_needed;
  } rbs_cfg_type;

  // Soft reset sources from the core.
  typedef struct packed {
    logic watchdog_timeout;
    logic reset_instr;
    logic stack_overflow;
    logic stack_underflow;
    logic prog_mode_exit;
  } rbs_src_type;

endpackage : rbs_pkg

/* hw/rbs_sequencer.sv */
/*
  Reset and brown-out sequencer: combines all reset sources, times the
  power-up delay, filters brown-out dips and exposes the brown-out control
  register over Avalon-MM. Assumes the analogue monitors and the pin are
  already synchronous to sys_clk.
*/
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
module rbs_sequencer #(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = rbs_pkg::POWER_UP_DELAY_TIMER_CYC // Shorten in simulation.
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire rbs_pkg::rbs_cfg_type cfg,
  input wire rbs_pkg::rbs_src_type src,
  input wire logic supply_ok,
  input wire logic above_brownout_threshold,
  input wire logic brownout_circuit_ready,
  input wire logic external_reset_pin,
  input wire logic osc_start_done,
  input wire logic sleep_mode,
  input wire logic wake_request,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic brownout_enable,
  output logic brownout_reset,
  output logic wake_allowed,
  output logic gpio_pin_value,
  output logic core_reset_b
);
  import rbs_pkg::*;

  // ----------------------------------------------------------------------
  // Brown-out enable decode and dip filter.
  // ----------------------------------------------------------------------
  logic soft_en_r, soft_en_nxt; // Software brown-out enable.
  logic [15:0] dip_cnt_r, dip_cnt_nxt; // Length of current supply dip.
  logic bor_r, bor_nxt; // Filtered brown-out reset condition.
  logic bor_en_r, bor_en_nxt; // Detector powered.
  logic wake_r, wake_nxt; // Wake may proceed.
  logic bor_active; // Detector enabled and ready, so it protects.
  // Decode the mode into a detector enable; soft bit matters only in
  // software mode, so writes in other modes are stored but inert.
  always_comb begin
    case (cfg.brownout_mode_select)
      BOR_MODE_ON: bor_en_nxt = 1'b1;
      BOR_MODE_NOSLEEP: bor_en_nxt = !sleep_mode;
      BOR_MODE_SOFT: bor_en_nxt = soft_en_r;
      default: bor_en_nxt = 1'b0;
    endcase
  end
  // Protection takes effect only once the circuit reports ready.
  assign bor_active = bor_en_r && brownout_circuit_ready;
  // Count consecutive low cycles; short dips reset the count harmlessly.
  always_comb begin
    dip_cnt_nxt = 16'h0000;
    bor_nxt = 1'b0;
    if (bor_active && !above_brownout_threshold) begin
      dip_cnt_nxt = dip_cnt_r;
      if (dip_cnt_r < 16'(FILTER_CYC)) begin
        dip_cnt_nxt = dip_cnt_r + 16'h0001;
      end
      bor_nxt = (dip_cnt_r >= 16'(FILTER_CYC));
    end
  end
  // Wake gating: only off-in-sleep mode waits for the detector.
  always_comb begin
    if (cfg.brownout_mode_select == BOR_MODE_NOSLEEP) begin
      wake_nxt = wake_request && brownout_circuit_ready;
    end else begin
      wake_nxt = wake_request;
    end
  end
  // Registers of the brown-out path.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dip_cnt_r <= 16'h0000;
      bor_r <= 1'b0;
      bor_en_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      dip_cnt_r <= dip_cnt_nxt;
      bor_r <= bor_nxt;
      bor_en_r <= bor_en_nxt;
      wake_r <= wake_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // External pin filter and enable.
  // ----------------------------------------------------------------------
  logic pin_en; // Pin acts as reset.
  logic [2:0] pin_cnt_r, pin_cnt_nxt; // Low-level persistence counter.
  logic pin_rst_r, pin_rst_nxt; // Filtered pin reset request.
  logic gpio_r, gpio_nxt; // Pin value as general input.
  assign pin_en = cfg.ext_reset_pin_enable
                  || cfg.low_voltage_program_enable;
  // A short low glitch is ignored; the pin must stay low a few cycles.
  always_comb begin
    pin_cnt_nxt = 3'h0;
    pin_rst_nxt = 1'b0;
    gpio_nxt = pin_en ? 1'b0 : external_reset_pin;
    if (pin_en && !external_reset_pin) begin
      pin_cnt_nxt = pin_cnt_r;
      if (pin_cnt_r < 3'(EXTERNAL_RESET_PIN_FLT_CYC)) begin
        pin_cnt_nxt = pin_cnt_r + 3'h1;
      end
      pin_rst_nxt = (pin_cnt_r >= 3'(EXTERNAL_RESET_PIN_FLT_CYC - 1));
    end
  end
  // Registers of the pin path.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_cnt_r <= 3'h0;
      pin_rst_r <= 1'b0;
      gpio_r <= 1'b0;
    end else begin
      pin_cnt_r <= pin_cnt_nxt;
      pin_rst_r <= pin_rst_nxt;
      gpio_r <= gpio_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Start-up sequencer.
  // ----------------------------------------------------------------------
  rbs_state_type state_r, state_nxt; // Sequencer state.
  logic [23:0] power_up_delay_timer_cnt_r, power_up_delay_timer_cnt_nxt; // Power-up delay countdown.
  logic hold_r, hold_nxt; // Internal reset request, active high.
  logic power_event; // Power-on or brown-out condition present.
  logic start_ok; // Mode allows start-up now.
  logic soft_event; // Core-side reset source.
  assign power_event = !supply_ok || bor_r;
  assign soft_event = src.watchdog_timeout || src.reset_instr
                      || src.stack_overflow || src.stack_underflow
                      || src.prog_mode_exit;
  // In the two hardware modes start waits for a ready, good supply.
  assign start_ok = (cfg.brownout_mode_select == BOR_MODE_ON
                     || cfg.brownout_mode_select == BOR_MODE_NOSLEEP)
                    ? (brownout_circuit_ready && above_brownout_threshold)
                    : 1'b1;
  // The timer runs independently of the pin, so a held pin releases
  // straight into run once the delay has already expired.
  always_comb begin
    state_nxt = state_r;
    power_up_delay_timer_cnt_nxt = power_up_delay_timer_cnt_r;
    case (state_r)
      RBS_ST_HOLD: begin
        power_up_delay_timer_cnt_nxt = 24'(POWER_UP_DELAY_TIMER_CYCLES);
        if (!power_event) begin
          state_nxt = cfg.power_up_timer_enable_n ? RBS_ST_WAIT
                                                  : RBS_ST_POWER_UP_DELAY_TIMER;
        end
      end
      RBS_ST_POWER_UP_DELAY_TIMER: begin
        power_up_delay_timer_cnt_nxt = power_up_delay_timer_cnt_r - 24'h000001;
        if (power_up_delay_timer_cnt_r <= 24'h000001) begin
          state_nxt = RBS_ST_WAIT;
        end
      end
      RBS_ST_WAIT: begin
        if ((osc_start_done || !cfg.osc_start_needed)
            && !pin_rst_r && start_ok) begin
          state_nxt = RBS_ST_RUN;
        end
      end
      default: begin
        state_nxt = RBS_ST_RUN;
      end
    endcase
    if (power_event) begin
      state_nxt = RBS_ST_HOLD;
    end
    hold_nxt = (state_nxt != RBS_ST_RUN) || soft_event
               || pin_rst_r;
  end
  // Sequencer registers.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= RBS_ST_HOLD;
      power_up_delay_timer_cnt_r <= 24'h000000;
      hold_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      power_up_delay_timer_cnt_r <= power_up_delay_timer_cnt_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Reset output synchroniser.
  // ----------------------------------------------------------------------
  logic [RST_SYNC_LEN-1:0] rsync_r, rsync_nxt; // Release shift chain.
  // A held request clears the whole chain on the next edge; release walks the chain.
  always_comb begin
    rsync_nxt = {rsync_r[RST_SYNC_LEN-2:0], 1'b1};
    if (hold_r) begin
      rsync_nxt = '0;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsync_r <= '0;
    end else begin
      rsync_r <= rsync_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Avalon-MM register slave.
  // ----------------------------------------------------------------------
  logic [31:0] rdata_r, rdata_nxt; // Read data register.
  logic wait_r, wait_nxt; // Waitrequest: low for one cycle per access.

  // Soft enable returns to one on rst_b, power-on or brown-out only.
  always_comb begin
    soft_en_nxt = soft_en_r;
    if (!wait_r && avs_write && avs_address == OFF_BROWNOUT_CONTROL) begin
      soft_en_nxt = avs_writedata[BIT_SOFT_EN];
    end
    if (power_event) begin
      soft_en_nxt = BROWNOUT_SOFT_EN_RST;
    end
  end

  // One wait cycle then a single answer cycle; unmapped reads give zero.
  always_comb begin
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if (wait_r && (avs_read || avs_write)) begin
      wait_nxt = 1'b0;
      rdata_nxt = 32'h0000_0000;
      if (avs_read && avs_address == OFF_BROWNOUT_CONTROL) begin
        rdata_nxt[BIT_SOFT_EN] = soft_en_r;
        rdata_nxt[BIT_READY] = bor_active;
      end else if (avs_read && avs_address == OFF_SEQ_STATUS) begin
        rdata_nxt[1:0] = state_r;
        rdata_nxt[2] = bor_r;
        rdata_nxt[3] = pin_en;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_en_r <= BROWNOUT_SOFT_EN_RST;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      soft_en_r <= soft_en_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign brownout_enable = bor_en_r;
  assign brownout_reset = bor_r;
  assign wake_allowed = wake_r;
  assign gpio_pin_value = gpio_r;
  assign core_reset_b = rsync_r[RST_SYNC_LEN-1];

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  power_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !supply_ok |=> ##[1:2] !core_reset_b)
    else $error("Reset not held while supply low.");
  power_up_delay_timer_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_r == RBS_ST_HOLD && !power_event && !cfg.power_up_timer_enable_n
    |=> state_r == RBS_ST_POWER_UP_DELAY_TIMER)
    else $error("Power-up delay did not start.");
  power_up_delay_timer_skip_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_r == RBS_ST_HOLD && !power_event && cfg.power_up_timer_enable_n
    |=> state_r == RBS_ST_WAIT)
    else $error("Disabled power-up delay was used.");
  power_up_delay_timer_count_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_r == RBS_ST_POWER_UP_DELAY_TIMER && !power_event && power_up_delay_timer_cnt_r > 24'h000001
    |=> state_r == RBS_ST_POWER_UP_DELAY_TIMER
        && power_up_delay_timer_cnt_r == $past(power_up_delay_timer_cnt_r) - 24'h000001)
    else $error("Power-up delay countdown broken.");
  dip_filter_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(bor_r) |-> $past(dip_cnt_r) >= 16'(FILTER_CYC))
    else $error("Brown-out taken on a short dip.");
  soft_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.brownout_mode_select == BOR_MODE_SOFT && $stable(cfg)
    |=> brownout_enable == $past(soft_en_r))
    else $error("Soft mode enable not followed.");
  sleep_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.brownout_mode_select == BOR_MODE_NOSLEEP && sleep_mode
    |=> !brownout_enable)
    else $error("Detector on during sleep.");
  wake_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.brownout_mode_select == BOR_MODE_NOSLEEP && !brownout_circuit_ready
    |=> !wake_allowed)
    else $error("Wake passed before ready.");
  pin_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg.ext_reset_pin_enable && !cfg.low_voltage_program_enable
    |=> !pin_rst_r)
    else $error("Disabled pin caused reset.");
  run_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(state_r == RBS_ST_RUN)
    |-> $past(osc_start_done || !cfg.osc_start_needed)
    && !$past(pin_rst_r))
    else $error("Run entered before release conditions.");
  soft_src_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    src.watchdog_timeout |-> ##2 !core_reset_b)
    else $error("Watchdog did not reset the core.");

endmodule : rbs_sequencer

/* testbench/rbs_supply_model.sv */
/*
  Far-side model: supply comparators, brown-out detector and reset pin.
  Assumes the bench drives power_on and calls dip and press as tasks.
*/
`timescale 1ns/1ns
module rbs_supply_model (
  input wire logic sys_clk,
  input wire logic power_on,
  input wire logic brownout_enable,
  input wire logic [7:0] ready_lat,
  output logic supply_ok = 1'b0,
  output logic above_brownout_threshold = 1'b0,
  output logic brownout_circuit_ready = 1'b0,
  output logic external_reset_pin = 1'b1
);
  logic [7:0] rdy_cnt_r = 8'h00; // Detector settling count.
  int dip_r = 0; // Low-supply cycles still to run.
  int pin_r = 0; // Pin-low cycles still to run.
  // ----------------------------------------------------------------------
  // Analogue behaviour, updated once per clock.
  // ----------------------------------------------------------------------
  // The detector needs ready_lat cycles of power before it is ready.
  always @(posedge sys_clk) begin
    supply_ok <= power_on;
    above_brownout_threshold <= power_on && dip_r == 0;
    if (!brownout_enable || !power_on) begin
      rdy_cnt_r <= 8'h00;
    end else if (rdy_cnt_r != 8'hFF) begin
      rdy_cnt_r <= rdy_cnt_r + 8'h01;
    end
    brownout_circuit_ready <= brownout_enable && rdy_cnt_r >= ready_lat;
    // A released pin is pulled up, so it reads high.
    external_reset_pin <= pin_r == 0;
    if (dip_r > 0) dip_r <= dip_r - 1;
    if (pin_r > 0) pin_r <= pin_r - 1;
  end
  // Supply falls below the threshold for n cycles.
  task automatic dip(input int n);
    dip_r <= n;
  endtask : dip
  // Pin is pulled low for n cycles.
  task automatic press(input int n);
    pin_r <= n;
  endtask : press
endmodule : rbs_supply_model

/* testbench/rbs_sequencer_bench.sv */
/*
  Self-checking bench for the reset and brown-out sequencer.
  Assumes the supply model above and a shortened power-up delay.
*/
`timescale 1ns/1ns
module rbs_sequencer_bench;
  import rbs_pkg::*;
  localparam int POWER_UP_DELAY_TIMER = 20; // Shortened so the run stays brief.
  logic sys_clk = 1'b0, rst_b = 1'b0, power_on = 1'b0;
  rbs_cfg_type cfg = '0;
  rbs_src_type src = '0;
  logic sleep_mode = 1'b0, wake_request = 1'b0, osc_start_done = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
  logic avs_waitrequest, brownout_enable, brownout_reset, wake_allowed;
  logic gpio_pin_value, core_reset_b, supply_ok, above_th, ready, pin;
  logic [7:0] ready_lat = 8'h28; // Slow detector at first.
  logic [31:0] exp_q[$]; // Expected read data, oldest first.
  int bad_count = 0, cmp_count = 0, seed = 32'h59EC5DCE;
  logic e;
  rbs_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER)) dut (.sys_clk(sys_clk),
    .rst_b(rst_b), .cfg(cfg), .src(src), .supply_ok(supply_ok),
    .above_brownout_threshold(above_th), .brownout_circuit_ready(ready),
    .external_reset_pin(pin), .osc_start_done(osc_start_done),
    .sleep_mode(sleep_mode), .wake_request(wake_request),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .brownout_enable(brownout_enable), .brownout_reset(brownout_reset),
    .wake_allowed(wake_allowed), .gpio_pin_value(gpio_pin_value),
    .core_reset_b(core_reset_b));
  rbs_supply_model far (.sys_clk(sys_clk), .power_on(power_on),
    .brownout_enable(brownout_enable), .ready_lat(ready_lat),
    .supply_ok(supply_ok), .above_brownout_threshold(above_th),
    .brownout_circuit_ready(ready), .external_reset_pin(pin));
  // ----------------------------------------------------------------------
  // Clock, checks and bus tasks.
  // ----------------------------------------------------------------------
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check_word(input logic [31:0] ex, input logic [31:0] g);
    cmp_count++;
    if (g !== ex) begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%0h got=%0h", $time, ex, g);
    end
  endtask : check_word
  task automatic check_bit(input logic ex, input logic g);
    check_word({31'h0, ex}, {31'h0, g});
  endtask : check_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // Holds the request until waitrequest is sampled low, then releases.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) check_bit(1'b0, 1'b1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] ex);
    exp_q.push_back(ex);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Read data is compared at the edge where the slave answers.
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      check_word(exp_q.pop_front(), avs_readdata);
    end
  end
  // Waits a bounded time for the core reset to reach a level.
  task automatic wait_core(input logic v, input int lim);
    int n;
    n = 0;
    while (core_reset_b !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    check_bit(v, core_reset_b);
  endtask : wait_core
  task automatic complete_run();
    $display("counts: compared %0d, failed %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // Watchdog: the tests need well under 5000 cycles.
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
  // ----------------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------------
  initial begin
    cfg.brownout_mode_select = BOR_MODE_ON;
    cyc(6);
    check_bit(1'b0, core_reset_b);
    rst_b <= 1'b1;
    cyc(30);
    check_bit(1'b0, core_reset_b);
    power_on <= 1'b1;
    cyc(POWER_UP_DELAY_TIMER);
    check_bit(1'b0, core_reset_b);
    cyc(12);
    check_bit(1'b0, core_reset_b);
    wait_core(1'b1, 80);
    $display("test power-up done");
    rd(OFF_BROWNOUT_CONTROL, 32'h81);
    d = $random(seed);
    d[7] = 1'b0;
    bus(1'b1, OFF_BROWNOUT_CONTROL, d);
    rd(OFF_BROWNOUT_CONTROL, 32'h01);
    rd(4'hC, 32'h0);
    rd(OFF_SEQ_STATUS, 32'h3);
    // Soft enable is 0 here, so soft mode keeps the detector off.
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        @(posedge sys_clk);
        cfg.brownout_mode_select <= m[1:0];
        sleep_mode <= s[0];
        cyc(4);
        e = (m == 3) || (m == 2 && s == 0);
        check_bit(e, brownout_enable);
      end
    end
    rd(OFF_BROWNOUT_CONTROL, 32'h00);
    bus(1'b1, OFF_BROWNOUT_CONTROL, 32'h80);
    cfg.brownout_mode_select <= BOR_MODE_SOFT;
    cyc(4);
    check_bit(1'b1, brownout_enable);
    $display("test modes done");
    cfg.brownout_mode_select <= BOR_MODE_NOSLEEP;
    sleep_mode <= 1'b1;
    wake_request <= 1'b1;
    cyc(3);
    check_bit(1'b0, wake_allowed);
    cfg.brownout_mode_select <= BOR_MODE_ON;
    ready_lat <= 8'h02;
    cyc(8);
    check_bit(1'b1, wake_allowed);
    wake_request <= 1'b0;
    sleep_mode <= 1'b0;
    cyc(10);
    $display("test wake done");
    far.dip(50);
    cyc(120);
    check_bit(1'b0, brownout_reset);
    check_bit(1'b1, core_reset_b);
    bus(1'b1, OFF_BROWNOUT_CONTROL, 32'h0);
    far.dip(150);
    wait_core(1'b0, 120);
    wait_core(1'b1, 200);
    rd(OFF_BROWNOUT_CONTROL, 32'h81);
    bus(1'b1, OFF_BROWNOUT_CONTROL, 32'h0);
    cfg.brownout_mode_select <= BOR_MODE_SOFT;
    far.dip(150);
    cyc(170);
    check_bit(1'b1, core_reset_b);
    cfg.brownout_mode_select <= BOR_MODE_ON;
    $display("test brown-out done");
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      cfg.ext_reset_pin_enable <= k[0];
      cfg.low_voltage_program_enable <= k[1];
      far.press(12);
      cyc(10);
      check_bit(k == 0, core_reset_b);
      check_bit(1'b0, gpio_pin_value);
      wait_core(1'b1, 40);
      cyc(5);
      check_bit(k == 0, gpio_pin_value);
    end
    $display("test pin done");
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      src <= rbs_src_type'(5'h01 << i);
      wait_core(1'b0, 5);
      src <= '0;
      wait_core(1'b1, 20);
    end
    $display("test sources done");
    // Mid-run reset with the delay timer off and the oscillator slow.
    @(posedge sys_clk);
    cfg.power_up_timer_enable_n <= 1'b1;
    cfg.osc_start_needed <= 1'b1;
    osc_start_done <= 1'b0;
    rst_b <= 1'b0;
    cyc(2);
    check_bit(1'b0, core_reset_b);
    rst_b <= 1'b1;
    cyc(12);
    check_bit(1'b0, core_reset_b);
    osc_start_done <= 1'b1;
    wait_core(1'b1, 8);
    rd(OFF_BROWNOUT_CONTROL, 32'h81);
    $display("test restart done");
    complete_run();
  end
endmodule : rbs_sequencer_bench
